/* File: core/tei_consts.svh */
// Offsets, field positions, reset values and timing counts of the touch event interrupt block
`ifndef TEI_CONSTS_SVH
`define TEI_CONSTS_SVH
`define TEI_ADDR_MAIN        12'h000
`define TEI_ADDR_STATUS      12'h004
`define TEI_ADDR_TOUCH       12'h008
`define TEI_ADDR_NOISE       12'h00C
`define TEI_ADDR_CONFIG      12'h010
`define TEI_ADDR_IRQ_EN      12'h014
`define TEI_ADDR_REPEAT_EN   12'h018
`define TEI_ADDR_PATTERN_CFG 12'h01C
`define TEI_ADDR_PATTERN     12'h020
`define TEI_ADDR_TIMING      12'h024
`define TEI_ADDR_POWER_CFG   12'h028
`define TEI_ADDR_SPIKE       12'h02C
`define TEI_MAIN_PEND_BIT    0
`define TEI_CFG_ANA_DIS_BIT  0
`define TEI_CFG_RF_DIS_BIT   1
`define TEI_CFG_RF_ONLY_BIT  2
`define TEI_CFG_SPIKE_BIT    3
`define TEI_CFG_REL_BIT      4
`define TEI_CFG_CALF_BIT     5
`define TEI_CFG_BCL_BIT      6
`define TEI_CFG_RESET        32'h0000_0010
`define TEI_IRQ_EN_RESET     8'hFF
`define TEI_REPEAT_EN_RESET  8'hFF
`define TEI_PATTERN_RESET    8'hFF
`define TEI_PATCFG_RESET     32'h0000_0000
`define TEI_TIMING_RESET     32'h0000_0037
`define TEI_POWER_RESET      32'h0000_0000
`define TEI_STAT_RESET_BIT   0
`define TEI_STAT_PATTERN_BIT 1
`define TEI_STAT_POWER_BIT   2
`define TEI_STAT_CALF_BIT    3
`define TEI_STAT_BCL_BIT     4
`define TEI_TICK_NS          1000000
`define TEI_CLK_NS           20
`define TEI_TICK_CYCLES      (`TEI_TICK_NS / `TEI_CLK_NS)
`endif

/* File: core/tei_pkg.sv */
// Types shared by the touch event interrupt block
package tei_pkg;
  typedef struct packed {
    logic       calFail;
    logic       baseLimit;
    logic       standby;
    logic [7:0] overTouch;
    logic [7:0] overNoise;
    logic [7:0] overPattern;
    logic [7:0] anaNoise;
    logic [7:0] rfNoise;
  } tei_sample_s;
  typedef enum logic [1:0] {
    TEI_IDLE,
    TEI_HELD,
    TEI_REPEAT
  } tei_chan_e;
endpackage : tei_pkg

/* File: core/tei_irq_core.sv */
// Touch event qualification, interrupt flag and alert output with APB registers
// What this block does
// - Pattern event when count or chosen set of inputs exceed pattern threshold or noisy
// - While pattern event active, every individual touch is blocked
// - Low-frequency noise rejects the sample and sets the noise flag by default
// - RF noise drops sample before threshold compare unless its disable bit set
// - Radio-only bit 0 flags any noise, 1 flags only RF noise
// - Analog noise blocks touch by default; disable bit removes blocking
// - Delta over noise but not touch threshold is a noise spike
// - With discard bit set, spikes are kept out of recalibration averaging
// - Any interrupt sets pending flag and alert until host clears flag
// - Host clear of pending flag also clears status bits at same write
// - Alert is active low, low while an interrupt is pending
// - Per-input enable gates touch interrupts
// - Enabled non-power inputs without repeat interrupt on touch and optionally on release
// - Repeat enabled: interrupts at repeat interval while touch held
// - Four-bit minimum hold timer splits plain touch from press-and-hold
// - Power button: no touch or repeat interrupt, only after hold time
// - Enabling power button enables its interrupt regardless of input enable
// - Matched pattern interrupts when pattern interrupt setting allows
// - Calibration failure with its enable raises interrupt
// - Base count limit flag with its enable raises interrupt
// - Leaving reset sets reset status and raises interrupt
// - Separate standby and active hold times; sets power button flag
`include "tei_consts.svh"

module tei_irq_core
  import tei_pkg::*;
#(
  parameter int CHANNELS = 8
) (
  input  wire logic                ref_clk,
  input  wire logic                sys_rst,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [11:0]         paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic                sampleValid,
  input  wire tei_sample_s         sample,
  output logic      [CHANNELS-1:0] recalKeep,
  output logic                     recalValid,
  output logic                     alertN
);

  ////////////////////////////////////////////////////////////////////////////
  logic [31:0]         configR;
  logic [7:0]          irqEnR;
  logic [7:0]          repeatEnR;
  logic [31:0]         patCfgR;
  logic [7:0]          patternR;
  logic [31:0]         timingR;
  logic [31:0]         powerCfgR;
  logic [7:0]          statusR;
  logic [7:0]          touchR;
  logic [7:0]          noiseR;
  logic [7:0]          spikeR;
  logic                pendingR;
  logic                rstEventR;
  logic [15:0]         tickCntR;
  logic                tickR;
  logic [3:0]          holdCnt [CHANNELS];
  logic [3:0]          repCnt [CHANNELS];
  tei_chan_e           chState [CHANNELS];
  logic [CHANNELS-1:0] touchEv;
  logic [CHANNELS-1:0] powerEv;
  logic                patternEv;
  logic                patActiveR;
  logic                wrAcc;
  logic                hostClear;

  function automatic logic [3:0] popCount(input logic [7:0] v);
    logic [3:0] c;
    c = 4'h0;
    for (int i = 0; i < 8; i++) begin
      c = c + {3'h0, v[i]};
    end
    return c;
  endfunction : popCount

  assign wrAcc     = psel & penable & pwrite;
  assign hostClear = wrAcc && paddr == `TEI_ADDR_MAIN && !pwdata[`TEI_MAIN_PEND_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Sample qualification
  logic [7:0] noiseFlag;
  logic [7:0] dropMask;
  logic [7:0] validTouch;
  logic [7:0] patHits;
  logic       patMatch;
  always_comb begin
    noiseFlag = sample.rfNoise | (configR[`TEI_CFG_RF_ONLY_BIT] ? 8'h00 : sample.anaNoise);
    // Inputs whose sample is thrown away for noise
    dropMask = 8'h00;
    if (!configR[`TEI_CFG_ANA_DIS_BIT]) begin
      dropMask = dropMask | sample.anaNoise;
    end
    if (!configR[`TEI_CFG_RF_DIS_BIT]) begin
      dropMask = dropMask | sample.rfNoise;
    end
    validTouch = sample.overTouch & ~dropMask;
    patHits = sample.overPattern | noiseFlag;
    if (patCfgR[1]) begin
      patMatch = (patHits & patternR) == patternR && patternR != 8'h00;
    end else begin
      patMatch = popCount(patHits) >= popCount(patternR) && patternR != 8'h00;
    end
    patMatch = patMatch & patCfgR[0];
  end

  // Spike: over noise, under touch threshold; threshold choice is done upstream by state
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      spikeR     <= 8'h00;
      recalKeep  <= '0;
      recalValid <= 1'b0;
    end else begin
      recalValid <= sampleValid;
      if (sampleValid) begin
        spikeR    <= sample.overNoise & ~sample.overTouch;
        // Discarded samples must not reach the averaging either
        recalKeep <= ~sample.overTouch & ~dropMask &
                     ~(configR[`TEI_CFG_SPIKE_BIT] ? sample.overNoise : 8'h00);
      end
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      touchR      <= 8'h00;
      noiseR      <= 8'h00;
      patActiveR  <= 1'b0;
    end else if (sampleValid) begin
      noiseR     <= noiseFlag;
      patActiveR <= patMatch;
      // Dropped sample keeps the last state; a zero would fake a release
      touchR     <= patMatch ? 8'h00 : validTouch | (touchR & dropMask);
    end
  end
  assign patternEv = sampleValid & patMatch & ~patActiveR;

  ////////////////////////////////////////////////////////////////////////////
  // Tick divider for hold and repeat timers; only one clock, a pulse paces them
  // Timers count whole ticks, so the first one may come up to a tick early
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      tickCntR <= 16'h0000;
      tickR    <= 1'b0;
    end else begin
      tickR    <= tickCntR == 16'(`TEI_TICK_CYCLES - 1);
      tickCntR <= tickCntR == 16'(`TEI_TICK_CYCLES - 1) ? 16'h0000 : tickCntR + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-channel touch state
  logic [2:0] powerCh;
  logic       powerOn;
  logic [3:0] powerHold;
  assign powerCh   = powerCfgR[2:0];
  assign powerOn   = sample.standby ? powerCfgR[4] : powerCfgR[3];
  assign powerHold = sample.standby ? powerCfgR[11:8] : powerCfgR[15:12];

  for (genvar c = 0; c < CHANNELS; c++) begin : gChan
    logic isPower;
    logic cur;
    logic prev;
    logic chEn;
    logic [3:0] holdNxt;
    logic [3:0] repNxt;
    assign holdNxt = holdCnt[c] + 4'h1;
    assign repNxt  = repCnt[c] + 4'h1;
    assign isPower = powerOn && powerCh == 3'(c);
    assign cur     = touchR[c];
    assign chEn    = irqEnR[c];
    always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
        chState[c] <= TEI_IDLE;
        holdCnt[c] <= 4'h0;
        repCnt[c]  <= 4'h0;
        prev       <= 1'b0;
        touchEv[c] <= 1'b0;
        powerEv[c] <= 1'b0;
      end else begin
        touchEv[c] <= 1'b0;
        powerEv[c] <= 1'b0;
        prev       <= cur;
        unique case (chState[c])
          TEI_IDLE: begin
            if (cur && !prev) begin
              chState[c] <= TEI_HELD;
              holdCnt[c] <= 4'h0;
              repCnt[c]  <= 4'h0;
              if (!isPower && !repeatEnR[c]) begin
                touchEv[c] <= chEn;
              end
            end
          end
          TEI_HELD: begin
            if (!cur) begin
              chState[c] <= TEI_IDLE;
              if (!isPower) begin
                // Short press with repeat counts as plain touch, reported at release
                touchEv[c] <= chEn & (repeatEnR[c] | configR[`TEI_CFG_REL_BIT]);
              end
            end else if (tickR) begin
              holdCnt[c] <= holdNxt;
              if (isPower && holdNxt >= powerHold) begin
                chState[c] <= TEI_REPEAT;
                powerEv[c] <= 1'b1;
              end else if (!isPower && repeatEnR[c] && holdNxt >= timingR[3:0]) begin
                chState[c] <= TEI_REPEAT;
                touchEv[c] <= chEn;
              end
            end
          end
          TEI_REPEAT: begin
            // Power button ignores repeat and only waits here for release
            if (!cur) begin
              chState[c] <= TEI_IDLE;
              touchEv[c] <= !isPower & chEn & configR[`TEI_CFG_REL_BIT];
            end else if (tickR && !isPower) begin
              repCnt[c] <= repNxt;
              if (repNxt >= timingR[7:4]) begin
                repCnt[c]  <= 4'h0;
                touchEv[c] <= chEn;
              end
            end
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status, pending flag and alert
  logic calFailEv;
  logic baseLimEv;
  logic anyEvent;
  logic calPrevR;
  logic basePrevR;
  logic pendingNxt;
  // Both flags are levels; only their rising edge counts
  assign calFailEv = sample.calFail & ~calPrevR;
  assign baseLimEv = sample.baseLimit & ~basePrevR;
  assign anyEvent  = (|touchEv) | (|powerEv) | (patternEv & patCfgR[2]) | rstEventR
                   | (calFailEv & configR[`TEI_CFG_CALF_BIT])
                   | (baseLimEv & configR[`TEI_CFG_BCL_BIT]);
  assign pendingNxt = anyEvent | (pendingR & ~hostClear);

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      calPrevR  <= 1'b0;
      basePrevR <= 1'b0;
      rstEventR <= 1'b1;
    end else begin
      calPrevR  <= sample.calFail;
      basePrevR <= sample.baseLimit;
      rstEventR <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      statusR <= 8'h00;
    end else begin
      // Event beats a clear landing in the same cycle
      statusR <= (hostClear ? 8'h00 : statusR)
               | {3'h0, baseLimEv, calFailEv, |powerEv, patternEv, rstEventR};
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pendingR <= 1'b0;
      alertN   <= 1'b1;
    end else begin
      pendingR <= pendingNxt;
      alertN   <= ~pendingNxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB register file, zero wait states
  // Writes land at the access edge; read-only and unmapped offsets ignore them
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      configR   <= `TEI_CFG_RESET;
      irqEnR    <= `TEI_IRQ_EN_RESET;
      repeatEnR <= `TEI_REPEAT_EN_RESET;
      patCfgR   <= `TEI_PATCFG_RESET;
      patternR  <= `TEI_PATTERN_RESET;
      timingR   <= `TEI_TIMING_RESET;
      powerCfgR <= `TEI_POWER_RESET;
    end else if (wrAcc) begin
      case (paddr)
        `TEI_ADDR_CONFIG:      configR   <= pwdata;
        `TEI_ADDR_IRQ_EN:      irqEnR    <= pwdata[7:0];
        `TEI_ADDR_REPEAT_EN:   repeatEnR <= pwdata[7:0];
        `TEI_ADDR_PATTERN_CFG: patCfgR   <= pwdata;
        `TEI_ADDR_PATTERN:     patternR  <= pwdata[7:0];
        `TEI_ADDR_TIMING:      timingR   <= pwdata;
        `TEI_ADDR_POWER_CFG:   powerCfgR <= pwdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      // Read data registered in setup, so pready rises in the access cycle
      pready  <= psel & ~penable;
      pslverr <= 1'b0;
      if (psel && !penable) begin
        prdata <= 32'h0000_0000;
        unique case (paddr)
          `TEI_ADDR_MAIN:        prdata <= {31'h0, pendingR};
          `TEI_ADDR_STATUS:      prdata <= {24'h0, statusR};
          `TEI_ADDR_TOUCH:       prdata <= {24'h0, touchR};
          `TEI_ADDR_NOISE:       prdata <= {24'h0, noiseR};
          `TEI_ADDR_CONFIG:      prdata <= configR;
          `TEI_ADDR_IRQ_EN:      prdata <= {24'h0, irqEnR};
          `TEI_ADDR_REPEAT_EN:   prdata <= {24'h0, repeatEnR};
          `TEI_ADDR_PATTERN_CFG: prdata <= patCfgR;
          `TEI_ADDR_PATTERN:     prdata <= {24'h0, patternR};
          `TEI_ADDR_TIMING:      prdata <= timingR;
          `TEI_ADDR_POWER_CFG:   prdata <= powerCfgR;
          `TEI_ADDR_SPIKE:       prdata <= {24'h0, spikeR};
          default:               pslverr <= 1'b1;
        endcase
      end
    end
  end

endmodule : tei_irq_core

/* File: tb/tei_irq_sva.sv */
// Port assertions for the touch event interrupt core
`include "tei_consts.svh"
module tei_irq_sva
  import tei_pkg::*;
#(
  parameter int CHANNELS = 8
) (
  input wire logic                ref_clk,
  input wire logic                sys_rst,
  input wire logic                psel,
  input wire logic                penable,
  input wire logic                pwrite,
  input wire logic [11:0]         paddr,
  input wire logic [31:0]         pwdata,
  input wire logic [31:0]         prdata,
  input wire logic                pready,
  input wire logic                pslverr,
  input wire logic                sampleValid,
  input wire tei_sample_s         sample,
  input wire logic [CHANNELS-1:0] recalKeep,
  input wire logic                recalValid,
  input wire logic                alertN
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  logic wrClr;
  assign wrClr = psel && penable && pwrite && paddr == `TEI_ADDR_MAIN && !pwdata[`TEI_MAIN_PEND_BIT];
  //////////////////////////////
  a_access_ready: assert property (psel && penable |-> pready)
    else $error("no ready in access phase");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_recal_follow: assert property (sampleValid |=> recalValid)
    else $error("recal strobe missing");
  a_recal_cause: assert property (recalValid |-> $past(sampleValid))
    else $error("recal strobe without sample");
  a_keep_touch: assert property (sampleValid |=> (recalKeep & CHANNELS'($past(sample.overTouch))) == '0)
    else $error("touched input kept for averaging");
  a_alert_hold: assert property (!alertN && !wrClr && !$past(wrClr) |=> !alertN)
    else $error("alert released without clear");
  a_alert_rise: assert property ($rose(alertN) |-> $past(wrClr))
    else $error("alert rose without host clear");
  a_reset_alert: assert property ($fell(sys_rst) |-> ##2 !alertN)
    else $error("no alert after reset");
endmodule : tei_irq_sva

bind tei_irq_core tei_irq_sva #(.CHANNELS(CHANNELS)) u_sva (.ref_clk, .sys_rst, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .sampleValid, .sample, .recalKeep, .recalValid, .alertN);

/* File: tb/tei_apb_host.sv */
// Host controller model that reaches the core registers over APB
module tei_apb_host (
  input  wire logic        ref_clk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [11:0]      paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
  end
  // Waits as long as the slave needs; only the bench watchdog ends a hang
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd, output logic err);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
endmodule : tei_apb_host

/* File: tb/touch_event_interrupt_logic_bench.sv */
// Self-checking bench for the touch event interrupt core
`include "tei_consts.svh"
module touch_event_interrupt_logic_bench
  import tei_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk = 1'b0, sys_rst = 1'b1, sampleValid = 1'b0;
  logic        psel, penable, pwrite, pready, pslverr, recalValid, alertN, rdErr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdData;
  logic [7:0]  recalKeep, keepSeen;
  tei_sample_s sample = '0;
  int          nMismatch = 0, comparisons = 0;
  always #10 ref_clk = ~ref_clk;
  tei_apb_host host (.ref_clk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
  tei_irq_core #(.CHANNELS(8)) DUT (.ref_clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .sampleValid, .sample, .recalKeep, .recalValid, .alertN);
  //////////////////////////////
  task results;
    $display("comparisons %0d mismatches %0d", comparisons, nMismatch);
    if (nMismatch == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : results
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      nMismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task wr(input logic [11:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, rdData, rdErr);
  endtask : wr
  task rd(input logic [11:0] a, input logic [31:0] e);
    host.xfer(1'b0, a, 32'h0, rdData, rdErr);
    chk($sformatf("reg %h", a), rdData, e);
  endtask : rd
  task al(input logic e);
    chk("alertN", {31'h0, alertN}, {31'h0, e});
  endtask : al
  // Alert is registered at the same edge as the flag; looking two edges on leaves margin
  task clr;
    wr(`TEI_ADDR_MAIN, 32'h0);
    repeat (2) @(posedge ref_clk);
    al(1'b1);
  endtask : clr
  // Touch path takes three edges from strobe to alert: touchR, touchEv, then alertN
  task send(input logic [2:0] f, input logic [7:0] ot, on, op, an, rn);
    @(posedge ref_clk);
    sampleValid <= 1'b1;
    sample <= {f, ot, on, op, an, rn};
    @(posedge ref_clk);
    sampleValid <= 1'b0;
    @(posedge ref_clk);
    keepSeen = recalKeep;
    repeat (6) @(posedge ref_clk);
  endtask : send
  task idle;
    send(3'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0);
  endtask : idle
  //////////////////////////////
  initial begin
    #1500000;
    nMismatch++;
    results;
  end
  initial begin
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge ref_clk);
    al(1'b0);
    rd(`TEI_ADDR_STATUS, 32'h1);
    rd(`TEI_ADDR_MAIN, 32'h1);
    rd(`TEI_ADDR_CONFIG, `TEI_CFG_RESET);
    rd(`TEI_ADDR_TIMING, `TEI_TIMING_RESET);
    rd(12'h100, 32'h0);
    chk("slverr", {31'h0, rdErr}, 32'h1);
    clr;
    rd(`TEI_ADDR_STATUS, 32'h0);
    wr(`TEI_ADDR_REPEAT_EN, 32'h0);
    send(3'h0, 8'h01, 8'h0, 8'h0, 8'h0, 8'h0);
    al(1'b0);
    rd(`TEI_ADDR_TOUCH, 32'h1);
    clr;
    idle;
    al(1'b0);
    clr;
    wr(`TEI_ADDR_IRQ_EN, 32'hFE);
    send(3'h0, 8'h01, 8'h0, 8'h0, 8'h0, 8'h0);
    al(1'b1);
    idle;
    al(1'b1);
    wr(`TEI_ADDR_IRQ_EN, 32'hFF);
    send(3'h0, 8'h08, 8'h0, 8'h0, 8'h08, 8'h0);
    al(1'b1);
    rd(`TEI_ADDR_TOUCH, 32'h0);
    rd(`TEI_ADDR_NOISE, 32'h08);
    wr(`TEI_ADDR_CONFIG, 32'h14);
    send(3'h0, 8'h0, 8'h0, 8'h0, 8'h08, 8'h0);
    chk("recalKeep", {24'h0, keepSeen}, 32'hF7);
    rd(`TEI_ADDR_NOISE, 32'h0);
    send(3'h0, 8'h08, 8'h0, 8'h0, 8'h0, 8'h08);
    al(1'b1);
    rd(`TEI_ADDR_NOISE, 32'h08);
    idle;
    wr(`TEI_ADDR_CONFIG, 32'h18);
    send(3'h0, 8'h01, 8'h03, 8'h0, 8'h0, 8'h0);
    chk("recalKeep", {24'h0, keepSeen}, 32'hFC);
    rd(`TEI_ADDR_SPIKE, 32'h02);
    clr;
    wr(`TEI_ADDR_CONFIG, 32'h10);
    send(3'h0, 8'h01, 8'h03, 8'h0, 8'h0, 8'h0);
    chk("recalKeep", {24'h0, keepSeen}, 32'hFE);
    idle;
    clr;
    wr(`TEI_ADDR_PATTERN, 32'h03);
    for (int m = 0; m < 2; m++) begin
      wr(`TEI_ADDR_PATTERN_CFG, {29'h0, 1'b1, m[0], 1'b1});
      send(3'h0, 8'h0, 8'h0, 8'h30, 8'h0, 8'h0);
      al(m[0]);
      clr;
      idle;
    end
    send(3'h0, 8'h0, 8'h0, 8'h03, 8'h0, 8'h0);
    al(1'b0);
    rd(`TEI_ADDR_STATUS, 32'h2);
    clr;
    send(3'h0, 8'h04, 8'h0, 8'h03, 8'h0, 8'h0);
    al(1'b1);
    idle;
    clr;
    wr(`TEI_ADDR_PATTERN_CFG, 32'h0);
    wr(`TEI_ADDR_CONFIG, 32'h30);
    send(3'h4, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0);
    al(1'b0);
    rd(`TEI_ADDR_STATUS, 32'h8);
    clr;
    wr(`TEI_ADDR_CONFIG, 32'h50);
    send(3'h2, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0);
    al(1'b0);
    rd(`TEI_ADDR_STATUS, 32'h10);
    clr;
    rd(`TEI_ADDR_STATUS, 32'h0);
    wr(`TEI_ADDR_REPEAT_EN, 32'h1);
    send(3'h0, 8'h01, 8'h0, 8'h0, 8'h0, 8'h0);
    al(1'b1);
    idle;
    al(1'b0);
    clr;
    wr(`TEI_ADDR_IRQ_EN, 32'hFB);
    wr(`TEI_ADDR_POWER_CFG, 32'h100A);
    send(3'h0, 8'h04, 8'h0, 8'h0, 8'h0, 8'h0);
    al(1'b1);
    // Hold of one tick; the free-running tick lands within one tick period
    for (int k = 0; k < 60000 && alertN === 1'b1; k++) begin
      @(posedge ref_clk);
    end
    al(1'b0);
    rd(`TEI_ADDR_STATUS, 32'h4);
    results;
  end
endmodule : touch_event_interrupt_logic_bench
